// ==== rtc_pkg.sv ====
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_READ_SYNC = 6'h02;
  localparam logic [5:0] IDX_EVENT_OUTPUT_CONTROL = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h0a;
  localparam logic [5:0] IDX_COUNT = 6'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SOFT_RESET_TRIGGER = 0;
  localparam int CTRL_ENABLE = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_HOUR = 6;
  localparam int CTRL_COM = 7;
  localparam int CTRL_PRESC_LO = 8;
  localparam int RS_READ_SYNC_REQUEST_BIT = 15;
  localparam int RS_READ_SYNC_CONTINUOUS = 14;
  localparam int EV_OVF = 15;
  localparam int EV_CMP_LO = 8;
  localparam int ST_BUSY = 7;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] READ_SYNC_RESET = 16'h0010;
  localparam logic [5:0] READ_SYNC_TARGET = 6'h10;
  localparam logic [15:0] EVENT_OUTPUT_CONTROL_RESET = 16'h0000;
  localparam logic [3:0] PRESC_MAX = 4'ha;
  localparam int PRESC_W = 10;

  // Operating modes.
  typedef enum logic [1:0] {
    RTC_MODE_WIDE = 2'h0,
    RTC_MODE_NARROW = 2'h1,
    RTC_MODE_CAL = 2'h2,
    RTC_MODE_RSVD = 2'h3
  } rtc_mode_t;

  // Control fields that steer the counter datapath.
  typedef struct packed {
    logic [3:0] prescaler;
    logic clear_on_match;
    logic hour_format_select;
    rtc_mode_t mode;
    logic enable;
  } rtc_ctrl_t;

  // Matches and updates reported by the counter datapath.
  typedef struct packed {
    logic overflow;
    logic [1:0] compare;
    logic [7:0] periodic;
    logic update;
  } rtc_match_t;

  // Gated event outputs.
  typedef struct packed {
    logic overflow;
    logic [1:0] compare;
    logic alarm;
    logic [7:0] periodic;
  } rtc_event_t;

endpackage

// ==== rtc_ctrl_sync.sv ====
// Register access over APB was decided locally.
`timescale 1ns/1ps

import rtc_pkg::*;

module rtc_ctrl_sync (
  input wire logic sys_clk_i, // System clock, 10 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB direction, high for write.
  input wire logic [7:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error on unmapped address.
  input wire logic source_clock_in_i, // Source clock pin, sampled.
  input wire rtc_pkg::rtc_match_t match_i, // Datapath matches.
  input wire logic [31:0] count_value_i, // Live counter or clock value.
  output logic counter_tick_clock_o, // One-cycle counter tick enable.
  output rtc_pkg::rtc_ctrl_t ctrl_o, // Control fields to datapath.
  output logic count_clear_o, // Clear counter on match.
  output logic count_wr_o, // Software write to counter register.
  output logic [31:0] count_wdata_o, // Data of that write.
  output rtc_pkg::rtc_event_t event_o // Gated event pulses.
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Writable bits of the event control register for a mode.
  function automatic logic [15:0] ev_mask(input rtc_mode_t m);
    logic [15:0] k;
    k = 16'h80ff;
    if (m == RTC_MODE_NARROW) begin
      k[EV_CMP_LO+1] = 1'b1;
    end
    k[EV_CMP_LO] = 1'b1;
    return k;
  endfunction

  // Low-bit mask of the prescaler counter for a code.
  function automatic logic [PRESC_W-1:0] div_mask(input logic [3:0] p);
    logic [3:0] c;
    logic [PRESC_W:0] one;
    c = (p > PRESC_MAX) ? PRESC_MAX : p;
    one = (PRESC_W+1)'(1) << c;
    return PRESC_W'(one - (PRESC_W+1)'(1));
  endfunction

  // ----------------------------------------------------------------
  // Bus side
  // ----------------------------------------------------------------
  logic pready_q;
  logic [5:0] idx;
  logic hit;
  logic wr;
  logic bus_w1;
  logic srst_now;
  rtc_ctrl_t ctrl_q;
  logic soft_reset_trigger_q;
  logic [15:0] ev_q;
  logic read_sync_request_bit_q;
  logic read_sync_continuous_q;
  logic pend_en_q;
  logic busy;
  logic [31:0] sync_value_q;
  logic [15:0] rd_ctrl;
  logic [15:0] rd_rs;

  assign idx = paddr_i[7:2];
  assign hit = (paddr_i[1:0] == 2'h0) &&
               (idx == IDX_CTRL || idx == IDX_READ_SYNC || idx == IDX_EVENT_OUTPUT_CONTROL ||
                idx == IDX_STATUS || idx == IDX_COUNT);
  assign wr = psel_i && penable_i && pready_q && pwrite_i && hit;
  assign bus_w1 = wr && (idx == IDX_CTRL);
  assign srst_now = bus_w1 && pwdata_i[CTRL_SOFT_RESET_TRIGGER];
  assign busy = soft_reset_trigger_q | pend_en_q | read_sync_request_bit_q;

  // One wait state: ready rises on the second access cycle.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_q <= psel_i && penable_i && !pready_q;
      pslverr_o <= psel_i && penable_i && !pready_q && !hit;
    end
  end
  assign pready_o = pready_q;

  // Read data views; reserved bits are zero.
  always_comb begin
    rd_ctrl = 16'h0000;
    rd_ctrl[CTRL_PRESC_LO +: 4] = ctrl_q.prescaler;
    rd_ctrl[CTRL_COM] = ctrl_q.clear_on_match;
    rd_ctrl[CTRL_HOUR] = ctrl_q.hour_format_select;
    rd_ctrl[CTRL_MODE_LO +: 2] = ctrl_q.mode;
    rd_ctrl[CTRL_ENABLE] = ctrl_q.enable;
    rd_ctrl[CTRL_SOFT_RESET_TRIGGER] = soft_reset_trigger_q;
    rd_rs = 16'h0000;
    rd_rs[RS_READ_SYNC_CONTINUOUS] = read_sync_continuous_q;
    rd_rs[5:0] = READ_SYNC_TARGET;
  end

  // Read data register, loaded in the first access cycle.
  // reserved zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_q && !pwrite_i) begin
      case (idx)
        IDX_CTRL: prdata_o <= {16'h0000, rd_ctrl};
        IDX_READ_SYNC: prdata_o <= {16'h0000, rd_rs};
        IDX_EVENT_OUTPUT_CONTROL: prdata_o <= {16'h0000, ev_q};
        IDX_STATUS: prdata_o <= {24'h00_0000, busy, 7'h00};
        IDX_COUNT: prdata_o <= sync_value_q;
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Source clock sampling and prescaler
  // ----------------------------------------------------------------
  logic [2:0] src_q;
  logic src_lvl_q;
  logic src_edge;
  logic [PRESC_W-1:0] pcnt_q;
  logic tick;

  // Three-stage sampler; a level counts once stages two and three agree.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_q <= 3'h0;
      src_lvl_q <= 1'b0;
    end else begin
      src_q <= {src_q[1:0], source_clock_in_i};
      if (src_q[1] == src_q[2]) begin
        src_lvl_q <= src_q[2];
      end
    end
  end
  assign src_edge = (src_q[1] == src_q[2]) && src_q[2] && !src_lvl_q;

  assign tick = src_edge && ((pcnt_q & div_mask(ctrl_q.prescaler)) ==
                             div_mask(ctrl_q.prescaler));

  // Free-running prescaler count on source edges.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcnt_q <= '0;
      counter_tick_clock_o <= 1'b0;
    end else begin
      if (src_edge) begin
        pcnt_q <= pcnt_q + PRESC_W'(1);
      end
      counter_tick_clock_o <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
    end else if (srst_now) begin
      ctrl_q <= '0;
    end else if (bus_w1) begin
      ctrl_q.prescaler <= pwdata_i[CTRL_PRESC_LO +: 4];
      ctrl_q.mode <= rtc_mode_t'(pwdata_i[CTRL_MODE_LO +: 2]);
      ctrl_q.enable <= pwdata_i[CTRL_ENABLE];
      if (!ctrl_q.enable) begin
        ctrl_q.clear_on_match <= pwdata_i[CTRL_COM];
        ctrl_q.hour_format_select <= pwdata_i[CTRL_HOUR];
      end
    end
  end

  // Soft reset flag, held until the counter domain has taken it.
  // clears with busy
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_trigger_q <= 1'b0;
    end else if (srst_now) begin
      soft_reset_trigger_q <= 1'b1;
    end else if (tick) begin
      soft_reset_trigger_q <= 1'b0;
    end
  end

  // Pending enable change; a new write wins over the acknowledge.
  // handshake on tick
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_en_q <= 1'b0;
    end else if (bus_w1 && !srst_now) begin
      pend_en_q <= 1'b1;
    end else if (tick || srst_now) begin
      pend_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_q <= EVENT_OUTPUT_CONTROL_RESET;
    end else if (srst_now) begin
      ev_q <= EVENT_OUTPUT_CONTROL_RESET;
    end else if (wr && idx == IDX_EVENT_OUTPUT_CONTROL) begin
      ev_q <= pwdata_i[15:0] & ev_mask(ctrl_q.mode);
    end
  end

  // ----------------------------------------------------------------
  // Read synchronisation
  // ----------------------------------------------------------------

  // Continuous bit, cleared by a counter write or a zero write.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_sync_continuous_q <= READ_SYNC_RESET[RS_READ_SYNC_CONTINUOUS];
    end else if (srst_now) begin
      read_sync_continuous_q <= READ_SYNC_RESET[RS_READ_SYNC_CONTINUOUS];
    end else if (wr && idx == IDX_COUNT) begin
      read_sync_continuous_q <= 1'b0;
    end else if (wr && idx == IDX_READ_SYNC) begin
      read_sync_continuous_q <= pwdata_i[RS_READ_SYNC_CONTINUOUS];
    end
  end

  // Request flag; set wins over the acknowledge of the previous one.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_sync_request_bit_q <= READ_SYNC_RESET[RS_READ_SYNC_REQUEST_BIT];
    end else if (srst_now) begin
      read_sync_request_bit_q <= READ_SYNC_RESET[RS_READ_SYNC_REQUEST_BIT];
    end else if (wr && idx == IDX_READ_SYNC && pwdata_i[RS_READ_SYNC_REQUEST_BIT]) begin
      read_sync_request_bit_q <= 1'b1;
    end else if (tick && !read_sync_continuous_q) begin
      read_sync_request_bit_q <= 1'b0;
    end
  end

  // Value capture on the counter tick while a request is pending, or on each datapath update in continuous mode.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_value_q <= 32'h0000_0000;
    end else if (tick && read_sync_request_bit_q && !read_sync_continuous_q) begin
      sync_value_q <= count_value_i;
    end else if (read_sync_continuous_q && match_i.update) begin
      sync_value_q <= count_value_i;
    end
  end

  // Counter write forwarded to the datapath.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_wr_o <= 1'b0;
      count_wdata_o <= 32'h0000_0000;
    end else begin
      count_wr_o <= wr && idx == IDX_COUNT;
      if (wr && idx == IDX_COUNT) begin
        count_wdata_o <= pwdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter-domain control outputs
  // ----------------------------------------------------------------

  // Enable follows on the tick; soft reset disables at once.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.prescaler <= ctrl_q.prescaler;
      ctrl_o.mode <= ctrl_q.mode;
      ctrl_o.clear_on_match <= ctrl_q.clear_on_match;
      ctrl_o.hour_format_select <= ctrl_q.hour_format_select &&
                                   ctrl_q.mode == RTC_MODE_CAL;
      if (srst_now || soft_reset_trigger_q) begin
        ctrl_o.enable <= 1'b0;
      end else if (tick) begin
        ctrl_o.enable <= ctrl_q.enable;
      end
    end
  end

  // Clear on match in the wide counter and calendar modes.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_clear_o <= 1'b0;
    end else begin
      count_clear_o <= ctrl_q.clear_on_match && match_i.compare[0] &&
                       (ctrl_q.mode == RTC_MODE_WIDE || ctrl_q.mode == RTC_MODE_CAL);
    end
  end

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_o <= '0;
    end else begin
      event_o.overflow <= match_i.overflow && ev_q[EV_OVF];
      event_o.periodic <= match_i.periodic & ev_q[7:0];
      case (ctrl_q.mode)
        RTC_MODE_WIDE: begin
          event_o.compare <= {1'b0, match_i.compare[0] & ev_q[EV_CMP_LO]};
          event_o.alarm <= 1'b0;
        end
        RTC_MODE_NARROW: begin
          event_o.compare <= match_i.compare & ev_q[EV_CMP_LO +: 2];
          event_o.alarm <= 1'b0;
        end
        RTC_MODE_CAL: begin
          event_o.compare <= 2'h0;
          event_o.alarm <= match_i.compare[0] && ev_q[EV_CMP_LO];
        end
        default: begin
          event_o.compare <= 2'h0;
          event_o.alarm <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== rtc_chk_sva.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker of the control block.
// ------------------------------------------------------------
module rtc_chk
  import rtc_pkg::*;
(
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic pwrite_i, // Direction.
  input wire logic [7:0] paddr_i, // Address.
  input wire logic pready_o, // Ready.
  input wire logic pslverr_o, // Error.
  input wire rtc_pkg::rtc_match_t match_i, // Matches.
  input wire logic counter_tick_clock_o, // Tick.
  input wire rtc_pkg::rtc_ctrl_t ctrl_o, // Control.
  input wire logic count_clear_o, // Clear.
  input wire logic count_wr_o, // Counter write.
  input wire rtc_pkg::rtc_event_t event_o // Events.
);
  logic ctrl_wr;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Flags a control write that completes in this cycle.
  assign ctrl_wr = pready_o && pwrite_i && paddr_i == {IDX_CTRL, 2'b00};
  a_tick_spaced: assert property (counter_tick_clock_o |=> (!counter_tick_clock_o) [*5])
    else $error("ticks too close");
  a_clear_cause: assert property (count_clear_o |-> $past(match_i.compare[0] &&
    ctrl_o.clear_on_match && ctrl_o.mode != RTC_MODE_NARROW)) else $error("bad clear");
  // locked bit.
  // The field lands in the register at the write edge and on ctrl_o one edge later.
  a_com_by_write: assert property ($changed(ctrl_o.clear_on_match) |-> $past(ctrl_wr, 2))
    else $error("clear bit moved");
  a_hour_cal: assert property (ctrl_o.hour_format_select |-> ctrl_o.mode == RTC_MODE_CAL)
    else $error("hour format outside calendar");
  a_mode_direct: assert property ($changed(ctrl_o.mode) |-> $past(ctrl_wr, 2))
    else $error("mode moved without write");
  a_cnt_forward: assert property (count_wr_o |-> $past(pready_o && pwrite_i &&
    !pslverr_o && paddr_i == {IDX_COUNT, 2'b00})) else $error("stray counter write");
  a_ovf_gated: assert property (event_o.overflow |-> $past(match_i.overflow))
    else $error("overflow event without cause");
  a_cmp1_narrow: assert property (event_o.compare[1] |->
    $past(match_i.compare[1] && ctrl_o.mode == RTC_MODE_NARROW)) else $error("bad compare 1");
  a_alarm_cal: assert property (event_o.alarm |->
    $past(match_i.compare[0] && ctrl_o.mode == RTC_MODE_CAL)) else $error("bad alarm event");
  a_per_gated: assert property ((event_o.periodic & ~$past(match_i.periodic)) == 8'h00)
    else $error("periodic event without cause");
endmodule

bind rtc_ctrl_sync rtc_chk u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .match_i(match_i), .ctrl_o(ctrl_o),
  .counter_tick_clock_o(counter_tick_clock_o), .count_clear_o(count_clear_o),
  .count_wr_o(count_wr_o), .event_o(event_o)
);

// ==== rtc_dp_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Counter datapath stand-in facing the control block.
// ------------------------------------------------------------
module rtc_dp_model
  import rtc_pkg::*;
(
  input wire logic sys_clk_i, // Clock.
  input wire logic rst_i, // Reset, active high.
  input wire logic hold_i, // Freezes the source clock.
  input wire logic tick_i, // Counter tick.
  input wire rtc_pkg::rtc_ctrl_t ctrl_i, // Control fields.
  input wire logic wr_i, // Counter write.
  input wire logic [31:0] wdata_i, // Counter write data.
  input wire logic clr_i, // Clear on match.
  input wire rtc_pkg::rtc_match_t fire_i, // Matches asked for by the bench.
  output logic src_o, // Source clock.
  output rtc_pkg::rtc_match_t match_o, // Match pulses.
  output logic [31:0] value_o // Counter value.
);
  logic [1:0] div_q;
  // source clock: eight clocks a period, frozen while held.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
      src_o <= 1'b0;
    end else if (!hold_i) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        src_o <= ~src_o;
      end
    end
  end
  // counter: loads, clears on match, counts, flags each update.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_o <= 32'h0;
      match_o <= 12'h000;
    end else begin
      match_o <= fire_i;
      match_o.update <= wr_i || clr_i || (tick_i && ctrl_i.enable);
      if (wr_i) begin
        value_o <= wdata_i;
      end else if (clr_i) begin
        value_o <= 32'h0;
      end else if (tick_i && ctrl_i.enable) begin
        value_o <= value_o + 32'h1;
      end
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register-level bench of the control block.
// ------------------------------------------------------------
module tb;
  import rtc_pkg::*;
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_RS = {IDX_READ_SYNC, 2'b00};
  localparam logic [7:0] A_EV = {IDX_EVENT_OUTPUT_CONTROL, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CNT = {IDX_COUNT, 2'b00};
  logic sys_clk = 1'b0;
  logic rst, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, cval, cwdata, rv;
  logic pready, pslverr, src, tick, cclr, cwr, re;
  rtc_match_t match, fire = 12'h000;
  rtc_ctrl_t ctrl;
  rtc_event_t ev;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [11:0] ev_exp [4] = '{12'ha01, 12'he01, 12'h901, 12'h801};
  logic [15:0] ev_rb [4] = '{16'h8101, 16'h8301, 16'h8101, 16'h8101};

  rtc_ctrl_sync dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .source_clock_in_i(src), .match_i(match), .count_value_i(cval),
    .counter_tick_clock_o(tick), .ctrl_o(ctrl), .count_clear_o(cclr), .count_wr_o(cwr),
    .count_wdata_o(cwdata), .event_o(ev)
  );
  rtc_dp_model pm (
    .sys_clk_i(sys_clk), .rst_i(rst), .hold_i(hold), .tick_i(tick), .ctrl_i(ctrl),
    .wr_i(cwr), .wdata_i(cwdata), .clr_i(cclr), .fire_i(fire), .src_o(src),
    .match_o(match), .value_o(cval)
  );

  // Clock of 100 ns period.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  // Polls the status register until the busy flag drops.
  task automatic wait_sync();
    int k;
    k = 0;
    do begin
      apb(1'b0, A_ST, 32'h0);
      k++;
    end while (rv[ST_BUSY] !== 1'b0 && k < 4000);
    chk(rv, 32'h0);
  endtask
  task automatic sync_read(input logic [31:0] exp);
    apb(1'b1, A_RS, 32'h8000);
    wait_sync();
    rd(A_CNT, exp);
  endtask
  // Fires one cycle of matches and gathers every event that follows.
  task automatic fire_chk(input logic [11:0] f, input logic [11:0] exp);
    logic [11:0] acc;
    acc = 12'h000;
    @(posedge sys_clk);
    fire <= f;
    @(posedge sys_clk);
    fire <= 12'h000;
    repeat (4) begin
      @(posedge sys_clk);
      acc = acc | ev;
    end
    chk({20'h0, acc}, {20'h0, exp});
  endtask
  // Measures a full gap between two ticks for one prescaler code.
  task automatic tick_gap(input logic [3:0] p);
    int c;
    apb(1'b1, A_CTRL, {20'h0, p, 8'h02});
    // The first gap may still end on a tick of the old code, so the third is measured.
    repeat (3) begin
      c = 0;
      do begin
        @(posedge sys_clk);
        c++;
      end while (tick !== 1'b1 && c < 20000);
    end
    chk(c, 32'h8 << p);
  endtask

  // Main sequence.
  initial begin
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(A_CTRL, 32'h0);
    rd(A_RS, 32'h10);
    rd(A_EV, 32'h0);
    rd(8'h0c, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(1'b1, A_RS, 32'h3fff);
    rd(A_RS, 32'h10);
    apb(1'b1, A_CTRL, 32'hfffff0f8);
    rd(A_CTRL, 32'hc8);
    wait_sync();
    // The source is frozen after its synchroniser drains, so the sync stays pending.
    hold <= 1'b1;
    repeat (6) @(posedge sys_clk);
    apb(1'b1, A_CTRL, 32'hca);
    rd(A_CTRL, 32'hca);
    rd(A_ST, 32'h80);
    chk({31'h0, ctrl.enable}, 32'h0);
    hold <= 1'b0;
    wait_sync();
    chk({31'h0, ctrl.enable}, 32'h1);
    apb(1'b1, A_CTRL, 32'h0a);
    rd(A_CTRL, 32'hca);
    chk({31'h0, ctrl.hour_format_select}, 32'h1);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_CTRL, 32'h2 | (m << 2));
      repeat (2) @(posedge sys_clk);
      chk({30'h0, ctrl.mode}, m);
      apb(1'b1, A_EV, 32'h8301);
      rd(A_EV, {16'h0, ev_rb[m]});
      fire_chk(12'hffe, ev_exp[m]);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_EV, 32'h1 << i);
      fire_chk(12'hffe, 12'h001 << i);
    end
    apb(1'b1, A_EV, 32'h0);
    fire_chk(12'hffe, 12'h000);
    tick_gap(4'h0);
    tick_gap(4'h3);
    tick_gap(4'ha);
    apb(1'b1, A_CTRL, 32'h80);
    wait_sync();
    apb(1'b1, A_CNT, 32'h12345678);
    sync_read(32'h12345678);
    rd(A_RS, 32'h10);
    fire_chk(12'h200, 12'h000);
    sync_read(32'h0);
    apb(1'b1, A_RS, 32'h4000);
    rd(A_RS, 32'h4010);
    apb(1'b1, A_CTRL, 32'h82);
    repeat (300) @(posedge sys_clk);
    apb(1'b1, A_CTRL, 32'h80);
    for (int k = 0; k < 99 && ctrl.enable !== 1'b0; k++) begin
      @(posedge sys_clk);
    end
    rd(A_CNT, cval);
    apb(1'b1, A_CNT, 32'h0);
    rd(A_RS, 32'h10);
    wait_sync();
    hold <= 1'b1;
    repeat (6) @(posedge sys_clk);
    apb(1'b1, A_EV, 32'h8101);
    apb(1'b1, A_CTRL, 32'h0a0b);
    rd(A_CTRL, 32'h1);
    rd(A_ST, 32'h80);
    chk({23'h0, ctrl}, 32'h0);
    hold <= 1'b0;
    wait_sync();
    rd(A_CTRL, 32'h0);
    rd(A_EV, 32'h0);
    finish_test();
  end
endmodule
